/* File: rtl/sac_atten_ctrl.sv */
// Controller end: drives the attenuator pins for one command
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"
module sac_atten_ctrl
(
  input wire logic core_clk,
  input wire logic rst,
  sac_link_if.ctrl link,
  input wire logic cmdValid,
  input wire sac_pkg::sac_cmd_mode_type cmdMode,
  input wire sac_pkg::sac_word_type cmdWord,
  output logic cmdReady,
  output logic cmdDone,
  input wire logic bootSerial,
  input wire logic bootStrobe,
  input wire sac_pkg::sac_word_type bootWord,
  input wire logic bootSelLow,
  input wire logic bootSelHigh
);

  // Phase length covers clock phases, strobe width, setup and hold
  localparam logic [`SAC_CNT_W-1:0] PhaseLast =
    `SAC_CNT_W'(`SAC_CTRL_PHASE_CYC - 1);
  localparam logic [`SAC_CNT_W-1:0] BootLast =
    `SAC_CNT_W'(`SAC_BOOT_HOLD_CYC - 1);

  sac_pkg::sac_ctrl_state_type state_reg; // Sequencer
  logic [`SAC_CNT_W-1:0] cnt_reg; // Cycles in the current phase
  logic [2:0] bit_reg; // Serial bit index
  logic done_reg; // Completion pulse
  sac_pkg::sac_word_type out_reg; // Word still to shift
  sac_pkg::sac_word_type lines_reg; // Parallel line levels
  sac_pkg::sac_word_type word_reg; // Latched word, put on lines late
  logic data_reg; // Serial data pin
  logic clock_reg; // Serial clock pin, divided from core_clk
  logic strobe_reg; // Strobe pin
  logic select_reg; // Mode pin
  logic selLow_reg; // Power-up select pins
  logic selHigh_reg;
  logic phaseEnd; // Current phase is over
  logic accept; // Command taken this cycle

  assign phaseEnd = (cnt_reg == PhaseLast);
  assign accept = (state_reg == sac_pkg::SAC_ST_IDLE) && cmdValid;

  // Sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_reg <= sac_pkg::SAC_ST_BOOT;
    else
    begin
      case (state_reg)
        sac_pkg::SAC_ST_BOOT:
          if (cnt_reg == BootLast)
            state_reg <= sac_pkg::SAC_ST_IDLE;
        sac_pkg::SAC_ST_IDLE:
          if (cmdValid)
          begin
            case (cmdMode)
              sac_pkg::SAC_MODE_SERIAL:
                state_reg <= sac_pkg::SAC_ST_SHIFT_LO;
              sac_pkg::SAC_MODE_LATCHED:
                state_reg <= sac_pkg::SAC_ST_SETUP;
              default:
                state_reg <= sac_pkg::SAC_ST_HOLD;
            endcase
          end
        sac_pkg::SAC_ST_SHIFT_LO:
          if (phaseEnd)
            state_reg <= sac_pkg::SAC_ST_SHIFT_HI;
        sac_pkg::SAC_ST_SHIFT_HI:
          // Six rising edges, then commit
          if (phaseEnd)
            state_reg <= (bit_reg == 3'h5) ? sac_pkg::SAC_ST_SETUP
              : sac_pkg::SAC_ST_SHIFT_LO;
        sac_pkg::SAC_ST_SETUP:
          if (phaseEnd)
            state_reg <= sac_pkg::SAC_ST_STROBE;
        sac_pkg::SAC_ST_STROBE:
          if (phaseEnd)
            state_reg <= sac_pkg::SAC_ST_HOLD;
        sac_pkg::SAC_ST_HOLD:
          if (phaseEnd)
            state_reg <= sac_pkg::SAC_ST_IDLE;
        default:
          state_reg <= sac_pkg::SAC_ST_IDLE;
      endcase
    end
  end

  // Phase counter, restarts whenever a phase ends; in boot it runs on to the boot hold count
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (state_reg == sac_pkg::SAC_ST_IDLE)
      cnt_reg <= '0;
    else if (state_reg == sac_pkg::SAC_ST_BOOT)
      cnt_reg <= cnt_reg + `SAC_CNT_W'(1);
    else if (phaseEnd)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + `SAC_CNT_W'(1);
  end

  // Bit index across the shift phases
  always_ff @(posedge core_clk)
  begin
    if (rst || accept)
      bit_reg <= 3'h0;
    else if (state_reg == sac_pkg::SAC_ST_SHIFT_HI && phaseEnd)
      bit_reg <= bit_reg + 3'h1;
  end

  // Completion pulse at the end of the hold phase
  always_ff @(posedge core_clk)
  begin
    if (rst)
      done_reg <= 1'b0;
    else
      done_reg <= (state_reg == sac_pkg::SAC_ST_HOLD) && phaseEnd;
  end

  // Serial pins: clock divided down, data most significant first
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clock_reg <= 1'b0;
      data_reg <= 1'b0;
      out_reg <= '0;
    end
    else if (accept && cmdMode == sac_pkg::SAC_MODE_SERIAL)
    begin
      clock_reg <= 1'b0;
      data_reg <= cmdWord[`SAC_WORD_W-1];
      out_reg <= cmdWord;
    end
    else if (state_reg == sac_pkg::SAC_ST_SHIFT_LO && phaseEnd)
      clock_reg <= 1'b1;
    else if (state_reg == sac_pkg::SAC_ST_SHIFT_HI && phaseEnd)
    begin
      // Data moves only a full phase after the rising edge
      clock_reg <= 1'b0;
      data_reg <= out_reg[`SAC_WORD_W-2];
      out_reg <= {out_reg[`SAC_WORD_W-2:0], 1'b0};
    end
  end

  // Strobe, mode, lines and power-up select pins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      strobe_reg <= 1'b0;
      select_reg <= 1'b0;
      lines_reg <= '0;
      word_reg <= '0;
      selLow_reg <= 1'b0;
      selHigh_reg <= 1'b0;
    end
    else if (state_reg == sac_pkg::SAC_ST_BOOT)
    begin
      // Levels the attenuator reads when it chooses its first state
      strobe_reg <= bootStrobe;
      select_reg <= bootSerial;
      lines_reg <= bootWord;
      selLow_reg <= bootSelLow;
      selHigh_reg <= bootSelHigh;
    end
    else if (accept)
    begin
      select_reg <= (cmdMode == sac_pkg::SAC_MODE_SERIAL);
      word_reg <= cmdWord;
      if (cmdMode == sac_pkg::SAC_MODE_DIRECT)
      begin
        // Strobe stays high: the lines drive the state live
        strobe_reg <= 1'b1;
        lines_reg <= cmdWord;
      end
      else
        // Strobe low while lines change or bits load
        strobe_reg <= 1'b0;
    end
    else if (state_reg == sac_pkg::SAC_ST_SETUP && cnt_reg == '0 &&
      !select_reg)
      // Lines move a cycle after the strobe drops, never with it, so a
      // strobe left high by direct mode cannot pass the new word early
      lines_reg <= word_reg;
    else if (state_reg == sac_pkg::SAC_ST_SETUP && phaseEnd)
      strobe_reg <= 1'b1;
    else if (state_reg == sac_pkg::SAC_ST_STROBE && phaseEnd)
      strobe_reg <= 1'b0;
  end

  // Pin outputs, each straight from a flip-flop
  assign link.serialData = data_reg;
  assign link.serialClock = clock_reg;
  assign link.latchStrobe = strobe_reg;
  assign link.interfaceSelect = select_reg;
  assign link.attenWeight16db = lines_reg[`SAC_BIT_16DB];
  assign link.attenWeight8db = lines_reg[`SAC_BIT_8DB];
  assign link.attenWeight4db = lines_reg[`SAC_BIT_4DB];
  assign link.attenWeight2db = lines_reg[`SAC_BIT_2DB];
  assign link.attenWeight1db = lines_reg[`SAC_BIT_1DB];
  assign link.attenWeightHalfDb = lines_reg[`SAC_BIT_HALF_DB];
  assign link.powerupSelectLow = selLow_reg;
  assign link.powerupSelectHigh = selHigh_reg;
  assign cmdReady = (state_reg == sac_pkg::SAC_ST_IDLE);
  assign cmdDone = done_reg;

endmodule
`default_nettype wire

/* File: inc/sac_cfg.svh */
// Constants of the step attenuator control interface, both ends
// Notes on behaviour
// - Select low uses lines, high uses serial
// - Controller changes lines with strobe low, pulses; direct mode changes them with strobe high
// - Strobe high in parallel: lines pass directly
// - Six bits weigh 16,8,4,2,1,0.5 dB
// - Six-stage shift register feeds transparent latch
// - Shifting ignores the strobe level
// - Shift on each rising serial clock edge
// - Strobe high passes shift word; low holds
// - Controller shifts six bits, then pulses strobe
// - Serial clock no faster than 10 MHz
// - Serial clock phases at least 30 ns
// - Strobe pulse 30 ns serial, 10 ns parallel
// - Power-up state held until first word
// - Serial power-up loads from the six lines
// - Parallel power-up, strobe low: select bits choose
// - Parallel power-up, strobe high: lines decide
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// Attenuation word width and bit positions
`define SAC_WORD_W 6
`define SAC_BIT_16DB 5
`define SAC_BIT_8DB 4
`define SAC_BIT_4DB 3
`define SAC_BIT_2DB 2
`define SAC_BIT_1DB 1
`define SAC_BIT_HALF_DB 0

// State before the power-up choice is made
`define SAC_RESET_STATE 6'h00
// Power-up choices in parallel mode with strobe low
`define SAC_PUP_REF 6'h00
`define SAC_PUP_8DB 6'h10
`define SAC_PUP_16DB 6'h20
`define SAC_PUP_MAX 6'h3f

// One step in hundredths of a dB
`define SAC_STEP_CDB 12'h032

// Core clock rate
`define SAC_CORE_MHZ 40
// Serial clock limits
`define SAC_SCLK_MAX_MHZ 10
`define SAC_SCLK_PERIOD_CYC \
  ((`SAC_CORE_MHZ + `SAC_SCLK_MAX_MHZ - 1) / `SAC_SCLK_MAX_MHZ)
`define SAC_SCLK_PHASE_NS 30
`define SAC_SCLK_PHASE_CYC ((`SAC_SCLK_PHASE_NS * `SAC_CORE_MHZ + 999) / 1000)
// Strobe pulse widths
`define SAC_STRB_SER_NS 30
`define SAC_STRB_SER_CYC ((`SAC_STRB_SER_NS * `SAC_CORE_MHZ + 999) / 1000)
`define SAC_STRB_PAR_NS 10
`define SAC_STRB_PAR_CYC ((`SAC_STRB_PAR_NS * `SAC_CORE_MHZ + 999) / 1000)
// Phase length used by the controller, above every minimum above
`define SAC_CTRL_PHASE_CYC 4
// Cycles after reset before the device takes its power-up state
`define SAC_PUP_WAIT_CYC 8
// Cycles the controller holds its boot levels after reset
`define SAC_BOOT_HOLD_CYC 12
// Phase counter width
`define SAC_CNT_W 4

`endif

/* File: inc/sac_pkg.sv */
// Types shared by both ends of the attenuator control link
`include "sac_cfg.svh"
package sac_pkg;

  // One attenuation word, bit 5 is the 16 dB weight
  typedef logic [`SAC_WORD_W-1:0] sac_word_type;

  // Programming styles the controller offers
  typedef enum logic [1:0]
  {
    SAC_MODE_SERIAL = 2'h0,
    SAC_MODE_LATCHED = 2'h1,
    SAC_MODE_DIRECT = 2'h2
  } sac_cmd_mode_type;

  // Controller sequencer, Gray codes along the usual path
  typedef enum logic [2:0]
  {
    SAC_ST_BOOT = 3'h0,
    SAC_ST_IDLE = 3'h1,
    SAC_ST_SHIFT_LO = 3'h3,
    SAC_ST_SHIFT_HI = 3'h2,
    SAC_ST_SETUP = 3'h6,
    SAC_ST_STROBE = 3'h7,
    SAC_ST_HOLD = 3'h5
  } sac_ctrl_state_type;

endpackage

/* File: inc/sac_link_if.sv */
// Pin bundle between the attenuator and its controller
`timescale 1ns/1ps
`default_nettype none
interface sac_link_if;
  logic serialData; // Serial data pin
  logic serialClock; // Serial shift clock pin
  logic latchStrobe; // Latch strobe pin
  logic interfaceSelect; // Low parallel, high serial
  logic attenWeight16db; // Weight lines
  logic attenWeight8db;
  logic attenWeight4db;
  logic attenWeight2db;
  logic attenWeight1db;
  logic attenWeightHalfDb;
  logic powerupSelectLow; // Power-up select bits
  logic powerupSelectHigh;

  // Attenuator end only listens
  modport device
  (
    input serialData, serialClock, latchStrobe, interfaceSelect,
    input attenWeight16db, attenWeight8db, attenWeight4db,
    input attenWeight2db, attenWeight1db, attenWeightHalfDb,
    input powerupSelectLow, powerupSelectHigh
  );

  // Controller end drives every pin
  modport ctrl
  (
    output serialData, serialClock, latchStrobe, interfaceSelect,
    output attenWeight16db, attenWeight8db, attenWeight4db,
    output attenWeight2db, attenWeight1db, attenWeightHalfDb,
    output powerupSelectLow, powerupSelectHigh
  );
endinterface
`default_nettype wire

/* File: rtl/sac_pin_filter.sv */
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sac_pin_filter
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic pinOut
);

  logic meta_reg; // First stage, read only by the second
  logic mid_reg; // Second stage
  logic late_reg; // Third stage
  logic level_reg; // Accepted level

  // Shift chain; the first stage may go metastable
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      mid_reg <= 1'b0;
      late_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pinIn;
      mid_reg <= meta_reg;
      late_reg <= mid_reg;
    end
  end

  // Accept a change only when stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (rst)
      level_reg <= 1'b0;
    else if (mid_reg == late_reg)
      level_reg <= late_reg;
  end

  assign pinOut = level_reg;

endmodule
`default_nettype wire

/* File: rtl/sac_atten_device.sv */
// Attenuator end: pin sampling, shift register, latch, power-up
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"
module sac_atten_device
(
  input wire logic core_clk,
  input wire logic rst,
  sac_link_if.device link,
  output sac_pkg::sac_word_type attenState,
  output logic [11:0] attenCentiDb,
  output logic atReference,
  output logic atMaximum,
  output logic stateChanged,
  output logic powerupDone,
  output logic serialActive,
  output logic [2:0] bitsShifted
);

  // Positions of the pins in the sampled vector
  localparam int PinCount = 12;
  localparam int PinSelLow = 6;
  localparam int PinSelHigh = 7;
  localparam int PinMode = 8;
  localparam int PinStrobe = 9;
  localparam int PinData = 10;
  localparam int PinClock = 11;

  // Raw pins, all from outside this clock domain
  logic [PinCount-1:0] pinRaw;
  // Pins after the three-flop filter
  logic [PinCount-1:0] pinClean;
  // Control lines as one word
  sac_pkg::sac_word_type lineWord;
  // Power-up word chosen by the two select bits
  sac_pkg::sac_word_type pupWord;
  // Filtered copies of the single pins
  logic sClock;
  logic sData;
  logic sStrobe;
  logic sSerial;
  // Rising edge of the serial clock as seen here
  logic clockRise;
  // Power-up capture moment
  logic pupTake;

  logic clockPrev_reg; // Last filtered serial clock level
  sac_pkg::sac_word_type shift_reg; // Serial-in parallel-out stages
  sac_pkg::sac_word_type atten_reg; // Transparent latch output
  sac_pkg::sac_word_type atten_next; // Latch next value
  logic [`SAC_CNT_W-1:0] pupCnt_reg; // Wait before power-up capture
  logic pupDone_reg; // Power-up state taken
  logic changed_reg; // One-cycle pulse on any state change
  logic [2:0] bits_reg; // Bits shifted since the last commit
  logic [11:0] centi_reg; // State in hundredths of a dB

  // Gather every pin in one vector for the filter bank
  assign pinRaw[`SAC_BIT_16DB] = link.attenWeight16db;
  assign pinRaw[`SAC_BIT_8DB] = link.attenWeight8db;
  assign pinRaw[`SAC_BIT_4DB] = link.attenWeight4db;
  assign pinRaw[`SAC_BIT_2DB] = link.attenWeight2db;
  assign pinRaw[`SAC_BIT_1DB] = link.attenWeight1db;
  assign pinRaw[`SAC_BIT_HALF_DB] = link.attenWeightHalfDb;
  assign pinRaw[PinSelLow] = link.powerupSelectLow;
  assign pinRaw[PinSelHigh] = link.powerupSelectHigh;
  assign pinRaw[PinMode] = link.interfaceSelect;
  assign pinRaw[PinStrobe] = link.latchStrobe;
  assign pinRaw[PinData] = link.serialData;
  assign pinRaw[PinClock] = link.serialClock;

  // One filter per pin; every pin sees the same latency
  genvar gi;
  generate
    for (gi = 0; gi < PinCount; gi++)
    begin : gFilter
      sac_pin_filter uFilter
      (
        .core_clk(core_clk),
        .rst(rst),
        .pinIn(pinRaw[gi]),
        .pinOut(pinClean[gi])
      );
    end
  endgenerate

  // Filtered single signals
  assign lineWord = pinClean[`SAC_WORD_W-1:0];
  assign sClock = pinClean[PinClock];
  assign sData = pinClean[PinData];
  assign sStrobe = pinClean[PinStrobe];
  assign sSerial = pinClean[PinMode];
  assign clockRise = sClock & ~clockPrev_reg;
  assign pupTake = ~pupDone_reg &&
    (pupCnt_reg == `SAC_CNT_W'(`SAC_PUP_WAIT_CYC - 1));

  // Power-up table, high select bit first in the case label
  always_comb
  begin
    case ({pinClean[PinSelHigh], pinClean[PinSelLow]})
      2'h0: pupWord = `SAC_PUP_REF;
      2'h2: pupWord = `SAC_PUP_8DB;
      2'h1: pupWord = `SAC_PUP_16DB;
      2'h3: pupWord = `SAC_PUP_MAX;
      default: pupWord = `SAC_PUP_REF;
    endcase
  end

  // Edge finder for the serial clock, on the filtered level only
  always_ff @(posedge core_clk)
  begin
    if (rst)
      clockPrev_reg <= 1'b0;
    else
      clockPrev_reg <= sClock;
  end

  // Power-up wait; lets the filters settle on the pin levels
  // before the initial state is chosen
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pupCnt_reg <= '0;
      pupDone_reg <= 1'b0;
    end
    else if (pupTake)
      pupDone_reg <= 1'b1;
    else if (~pupDone_reg)
      pupCnt_reg <= pupCnt_reg + `SAC_CNT_W'(1);
  end

  // Shift register: strobe plays no part here
  always_ff @(posedge core_clk)
  begin
    if (rst)
      shift_reg <= `SAC_RESET_STATE;
    else if (pupTake && sSerial)
      // Keep the stages equal to the latch so an early strobe
      // pulse does not jump away from the power-up state
      shift_reg <= lineWord;
    else if (pupDone_reg && clockRise)
      // First bit sent walks up to the 16 dB stage
      shift_reg <= {shift_reg[`SAC_WORD_W-2:0], sData};
  end

  // Count of bits since the last commit, saturates at seven
  always_ff @(posedge core_clk)
  begin
    if (rst)
      bits_reg <= 3'h0;
    else if (sStrobe && sSerial)
      bits_reg <= 3'h0;
    else if (pupDone_reg && clockRise && bits_reg != 3'h7)
      bits_reg <= bits_reg + 3'h1;
  end

  // Next value of the attenuation latch
  always_comb
  begin
    atten_next = atten_reg;
    if (pupTake)
    begin
      if (sSerial)
        atten_next = lineWord;
      else if (sStrobe)
        atten_next = lineWord;
      else
        atten_next = pupWord;
    end
    else if (pupDone_reg && sStrobe)
    begin
      // Transparent while the strobe is high, source by mode pin
      if (sSerial)
        atten_next = shift_reg;
      else
        atten_next = lineWord;
    end
    // Strobe low: the latch holds, so the power-up state
    // stays until the first word is committed
  end

  // Attenuation latch itself
  always_ff @(posedge core_clk)
  begin
    if (rst)
      atten_reg <= `SAC_RESET_STATE;
    else
      atten_reg <= atten_next;
  end

  // Change pulse, for switching-rate bookkeeping outside
  always_ff @(posedge core_clk)
  begin
    if (rst)
      changed_reg <= 1'b0;
    else
      changed_reg <= (atten_next != atten_reg);
  end

  // Binary weights: the word counts half-dB steps
  always_ff @(posedge core_clk)
  begin
    if (rst)
      centi_reg <= 12'h000;
    else
      centi_reg <= 12'(atten_next * `SAC_STEP_CDB);
  end

  // Outputs from flip-flops or the filter bank; the two end flags decode atten_reg
  assign attenState = atten_reg;
  assign attenCentiDb = centi_reg;
  // Every one of the 64 words is legal; only the ends are flagged
  assign atReference = (atten_reg == `SAC_PUP_REF);
  assign atMaximum = (atten_reg == `SAC_PUP_MAX);
  assign stateChanged = changed_reg;
  assign powerupDone = pupDone_reg;
  assign serialActive = sSerial;
  assign bitsShifted = bits_reg;

endmodule
`default_nettype wire

/* File: verif/sac_link_asserts.sv */
// Checker for the attenuator link pins and the attenuation word
`timescale 1ns/1ps
`default_nettype none
module sac_link_asserts
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serialData,
  input wire logic serialClock,
  input wire logic latchStrobe,
  input wire logic interfaceSelect,
  input wire logic attenWeight16db,
  input wire logic attenWeight8db,
  input wire logic attenWeight4db,
  input wire logic attenWeight2db,
  input wire logic attenWeight1db,
  input wire logic attenWeightHalfDb,
  input wire logic powerupSelectLow,
  input wire logic powerupSelectHigh,
  input wire sac_pkg::sac_word_type attenState,
  input wire logic powerupDone
);
  // Weight lines as one word, bit 5 the 16 dB line
  logic [5:0] lineWord;
  assign lineWord = {attenWeight16db, attenWeight8db, attenWeight4db,
    attenWeight2db, attenWeight1db, attenWeightHalfDb};

  // One domain, so one clock and one reset for all
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Two cycles cover the 30 ns minimum at 25 ns a cycle
  clk_high_a:
    assert property ($rose(serialClock) |-> serialClock [*2])
      else $error("serial clock high phase too short");
  clk_low_a:
    assert property ($fell(serialClock) |-> !serialClock [*2])
      else $error("serial clock low phase too short");
  // Four cycles make 100 ns, the fastest legal period
  clk_rate_a:
    assert property ($rose(serialClock) |=> (!$rose(serialClock)) [*3])
      else $error("serial clock faster than allowed");
  strobe_width_a:
    assert property ($rose(latchStrobe) |-> latchStrobe [*2])
      else $error("strobe pulse too short");
  load_low_a:
    assert property (($rose(serialClock) && interfaceSelect) |-> !latchStrobe)
      else $error("serial bit shifted with strobe high");
  data_hold_a:
    assert property ($rose(serialClock) |->
      $stable(serialData) ##1 $stable(serialData))
      else $error("serial data moved around the clock edge");
  par_hold_a:
    assert property (($fell(latchStrobe) && !interfaceSelect) |->
      $stable(lineWord))
      else $error("weight lines moved as the strobe fell");
  // Filter lag is a few cycles, so seven low cycles mean a closed latch
  state_hold_a:
    assert property ((powerupDone && !latchStrobe) [*7] |->
      $stable(attenState))
      else $error("state moved while strobe low");
  dir_follow_a:
    assert property ((!interfaceSelect && latchStrobe && powerupDone &&
      $changed(lineWord)) |-> ##[3:8] (attenState == lineWord))
      else $error("state did not follow the weight lines");
  powerup_time_a:
    assert property ($fell(rst) |-> ##[6:9] powerupDone)
      else $error("power-up state not taken in time");
endmodule
`default_nettype wire

/* File: verif/test_step_attenuator_control_interface.sv */
// Bench joining controller and attenuator over one link
`timescale 1ns/1ps
`default_nettype none
module test_step_attenuator_control_interface;
  logic core_clk; // 40 MHz clock
  logic rst; // Synchronous reset
  logic cmdValid; // Command request
  sac_pkg::sac_cmd_mode_type cmdMode;
  sac_pkg::sac_word_type cmdWord;
  sac_pkg::sac_word_type bootWord; // Lines during boot
  logic cmdReady, cmdDone, bootSerial, bootStrobe, bootSelLow, bootSelHigh;
  sac_pkg::sac_word_type attenState; // Device word
  logic [11:0] attenCentiDb;
  logic atReference, atMaximum, stateChanged, powerupDone, serialActive;
  logic [2:0] bitsShifted;
  logic [5:0] capWord; // Last six bits seen on the wire
  int changeCount; // State change pulses seen
  int n_fail;
  int check_count;

  sac_link_if sac_link_if_i ();
  sac_atten_ctrl sac_atten_ctrl_i (.core_clk(core_clk), .rst(rst),
    .link(sac_link_if_i), .cmdValid(cmdValid), .cmdMode(cmdMode),
    .cmdWord(cmdWord), .cmdReady(cmdReady), .cmdDone(cmdDone),
    .bootSerial(bootSerial), .bootStrobe(bootStrobe), .bootWord(bootWord),
    .bootSelLow(bootSelLow), .bootSelHigh(bootSelHigh));
  sac_atten_device sac_atten_device_i (.core_clk(core_clk), .rst(rst),
    .link(sac_link_if_i), .attenState(attenState),
    .attenCentiDb(attenCentiDb), .atReference(atReference),
    .atMaximum(atMaximum), .stateChanged(stateChanged),
    .powerupDone(powerupDone), .serialActive(serialActive),
    .bitsShifted(bitsShifted));
  sac_link_asserts sac_link_asserts_i (.core_clk(core_clk), .rst(rst),
    .serialData(sac_link_if_i.serialData),
    .serialClock(sac_link_if_i.serialClock),
    .latchStrobe(sac_link_if_i.latchStrobe),
    .interfaceSelect(sac_link_if_i.interfaceSelect),
    .attenWeight16db(sac_link_if_i.attenWeight16db),
    .attenWeight8db(sac_link_if_i.attenWeight8db),
    .attenWeight4db(sac_link_if_i.attenWeight4db),
    .attenWeight2db(sac_link_if_i.attenWeight2db),
    .attenWeight1db(sac_link_if_i.attenWeight1db),
    .attenWeightHalfDb(sac_link_if_i.attenWeightHalfDb),
    .powerupSelectLow(sac_link_if_i.powerupSelectLow),
    .powerupSelectHigh(sac_link_if_i.powerupSelectHigh),
    .attenState(attenState), .powerupDone(powerupDone));

  // Free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Wire-side capture, first bit sent ends up on top
  always @(posedge sac_link_if_i.serialClock)
    capWord <= {capWord[4:0], sac_link_if_i.serialData};

  // Counts change pulses; each command may add at most one
  always @(posedge core_clk)
    if (stateChanged === 1'b1)
      changeCount++;

  // Inputs move 2 ns after the edge, clear of sampling
  task automatic tick;
    @(posedge core_clk);
    #2;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Pins are serial, strobe, select high, select low
  task automatic power_up(input logic [3:0] pins,
    input sac_pkg::sac_word_type w, input sac_pkg::sac_word_type exp);
    {bootSerial, bootStrobe, bootSelHigh, bootSelLow} = pins;
    bootWord = w;
    rst = 1'b1;
    repeat (10) tick;
    rst = 1'b0;
    repeat (10) tick;
    check(12'(powerupDone), 12'h001);
    check(12'(attenState), 12'(exp));
    repeat (2) tick;
    check(12'(attenState), 12'(exp));
  endtask

  // One command, then the settled word is judged
  task automatic send(input sac_pkg::sac_cmd_mode_type mode,
    input sac_pkg::sac_word_type w);
    int n;
    int startChanges;
    sac_pkg::sac_word_type prev;
    sac_pkg::sac_word_type startWord;
    n = 0;
    prev = attenState;
    while (cmdReady !== 1'b1 && n < 100)
    begin
      tick;
      n++;
    end
    startWord = attenState;
    startChanges = changeCount;
    cmdMode = mode;
    cmdWord = w;
    cmdValid = 1'b1;
    tick;
    cmdValid = 1'b0;
    check(12'(cmdReady), 12'h000);
    n = 0;
    while (cmdDone !== 1'b1 && n < 100)
    begin
      tick;
      n++;
      // Mode change may settle early; loading itself must not show
      if (n == 20)
        prev = attenState;
      if (mode == sac_pkg::SAC_MODE_SERIAL && n == 40)
        check(12'(attenState), 12'(prev));
      // Latched word waits for the strobe pulse
      if (mode == sac_pkg::SAC_MODE_LATCHED && n == 6)
        check(12'(attenState), 12'(startWord));
      if (mode == sac_pkg::SAC_MODE_SERIAL && n == 52)
        check(12'(bitsShifted), 12'h006);
    end
    check(12'(cmdDone), 12'h001);
    check(12'(cmdReady), 12'h001);
    repeat (8) tick;
    check(12'(attenState), 12'(w));
    check(attenCentiDb, 12'(w) * 12'h032);
    check(12'(atMaximum), 12'(w == 6'h3f));
    check(12'(atReference), 12'(w == 6'h00));
    check(12'(serialActive), 12'(mode == sac_pkg::SAC_MODE_SERIAL));
    check(12'(changeCount - startChanges), 12'(startWord != w));
    if (mode == sac_pkg::SAC_MODE_SERIAL)
    begin
      check(12'(capWord), 12'(w));
      check(12'(bitsShifted), 12'h000);
    end
  endtask

  task automatic test_power_up;
    power_up(4'h8, 6'h2b, 6'h2b);
    power_up(4'h0, 6'h2b, 6'h00);
    power_up(4'h2, 6'h2b, 6'h10);
    power_up(4'h1, 6'h2b, 6'h20);
    power_up(4'h3, 6'h2b, 6'h3f);
    power_up(4'h4, 6'h15, 6'h15);
  endtask

  // Back-to-back words, uneven patterns expose bit order
  task automatic test_serial;
    sac_pkg::sac_word_type w[6];
    w = '{6'h3f, 6'h2a, 6'h15, 6'h01, 6'h20, 6'h00};
    foreach (w[i])
      send(sac_pkg::SAC_MODE_SERIAL, w[i]);
  endtask

  task automatic test_latched;
    send(sac_pkg::SAC_MODE_LATCHED, 6'h2c);
    send(sac_pkg::SAC_MODE_LATCHED, 6'h13);
  endtask

  task automatic test_direct;
    send(sac_pkg::SAC_MODE_DIRECT, 6'h07);
    send(sac_pkg::SAC_MODE_DIRECT, 6'h38);
    // Strobe falls from direct mode; lines must not move with it
    send(sac_pkg::SAC_MODE_LATCHED, 6'h2d);
  endtask

  // Source follows the live select pin
  task automatic test_mode_switch;
    send(sac_pkg::SAC_MODE_DIRECT, 6'h11);
    send(sac_pkg::SAC_MODE_SERIAL, 6'h26);
    send(sac_pkg::SAC_MODE_LATCHED, 6'h19);
    send(sac_pkg::SAC_MODE_SERIAL, 6'h0b);
  endtask

  // Main sequence
  initial
  begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdMode = sac_pkg::SAC_MODE_SERIAL;
    cmdWord = 6'h00;
    bootWord = 6'h00;
    bootSerial = 1'b0;
    bootStrobe = 1'b0;
    bootSelLow = 1'b0;
    bootSelHigh = 1'b0;
    test_power_up;
    test_serial;
    test_latched;
    test_direct;
    test_mode_switch;
    test_done;
  end

  // Watchdog at 20000 cycles, far beyond the fewer than 1000 cycles needed
  initial
  begin
    #500000;
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
